// [hw/gmc_ctrl.sv]
`timescale 1ns/10ps
module gmc_ctrl
    import gmc_pkg::*;
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    // role straps
    input  wire logic       i_sys_ctrl,     // we are system controller
    input  wire logic       i_talk_only,    // no controller, talk only
    input  wire logic       i_listen_only,  // no controller, listen only
    // user send request
    input  wire logic       i_tx_valid,
    input  wire logic [7:0] i_tx_byte,
    input  wire logic       i_tx_cmd,       // byte is a command
    input  wire logic       i_tx_end,       // last byte of a string
    output logic            o_tx_ready,
    // user management requests: clear and remote pulses, poll and listen levels
    input  wire logic       i_ifc_req,
    input  wire logic       i_ren_set,
    input  wire logic       i_ren_clr,
    input  wire logic       i_poll_req,
    input  wire logic       i_listen_en,    // accept data as listener
    // user receive side
    output logic            o_rx_valid,
    output logic [7:0]      o_rx_byte,
    output logic            o_rx_cmd,
    output logic            o_rx_end,
    output gmc_msg_t        o_rx_msg,
    output logic [4:0]      o_rx_addr,
    output logic            o_cic,
    output logic            o_srq,
    // bus data lines, active low, open drain
    input  wire logic [7:0] i_dio_n,
    output logic      [7:0] o_dio_n,
    output logic      [7:0] o_dio_oe,
    // bus handshake lines
    input  wire logic       i_dav_n,
    output logic            o_dav_n,
    output logic            o_dav_oe,
    input  wire logic       i_nrfd_n,
    output logic            o_nrfd_n,
    output logic            o_nrfd_oe,
    input  wire logic       i_ndac_n,
    output logic            o_ndac_n,
    output logic            o_ndac_oe,
    // bus management lines
    input  wire logic       i_atn_n,
    output logic            o_atn_n,
    output logic            o_atn_oe,
    output logic            o_ifc_n,
    output logic            o_ifc_oe,
    output logic            o_ren_n,
    output logic            o_ren_oe,
    input  wire logic       i_srq_n,
    input  wire logic       i_eoi_n,
    output logic            o_eoi_n,
    output logic            o_eoi_oe
);
    // ************************************************************
    // declarations
    // ************************************************************
    typedef enum logic [2:0] {
        GMC_S_IDLE, GMC_S_WAIT_RDY, GMC_S_SETTLE, GMC_S_WAIT_ACC,
        GMC_S_WAIT_NDAC
    } gmc_src_t;
    typedef enum logic [1:0] {
        GMC_A_READY, GMC_A_ACCEPT, GMC_A_WAIT_END
    } gmc_acc_t;

    logic [13:0]          sync_in;     // synchronised bus inputs
    logic [7:0]           bus_data;    // true-level data
    logic                 dav, nrfd, ndac, atn, srq, eoi;
    gmc_src_t             src_reg;     // source handshake state
    gmc_acc_t             acc_reg;     // acceptor handshake state
    logic [GMC_CNT_W-1:0] settle_reg;  // settle counter
    logic [7:0]           txd_reg;     // byte being sourced
    logic                 txcmd_reg;   // byte is a command
    logic                 txend_reg;   // byte ends a string
    logic                 talk_reg;    // we are addressed talker
    logic                 ifc_reg;     // clear pulse active
    logic [GMC_CNT_W-1:0] ifc_cnt_reg; // clear pulse length
    logic                 strobe;      // byte accepted now
    logic                 dec_valid;
    gmc_msg_t             dec_msg;
    logic [4:0]           dec_addr;
    logic                 acceptor_on; // we take part as acceptor

    gmc_sync #(
        .W (14)
    ) u_sync (
        .i_mclk  (i_mclk),
        .i_async ({i_dio_n, i_dav_n, i_nrfd_n, i_ndac_n,
                   i_atn_n, i_srq_n, i_eoi_n}),
        .o_sync  (sync_in)
    );

    // bus lines sampled and inverted to true levels
    assign bus_data = ~sync_in[13:6];
    assign dav      = ~sync_in[5];
    assign nrfd     = ~sync_in[4];
    assign ndac     = ~sync_in[3];
    assign atn      = ~sync_in[2];
    assign srq      = ~sync_in[1];
    assign eoi      = ~sync_in[0];

    // commands are taken by everyone, data by listeners only
    assign acceptor_on = atn || i_listen_en || i_listen_only;

    // ************************************************************
    // source handshake
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            src_reg    <= GMC_S_IDLE;
            settle_reg <= '0;
            txd_reg    <= 8'h00;
            txcmd_reg  <= 1'b0;
            txend_reg  <= 1'b0;
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= 1'b0;
            unique case (src_reg)
                GMC_S_IDLE: begin
                    // commands need control; data need talk role
                    o_tx_ready <= 1'b1;
                    if (i_tx_valid && o_tx_ready &&
                        ((i_tx_cmd && o_cic) ||
                         (!i_tx_cmd && (talk_reg || i_talk_only)))) begin
                        txd_reg    <= i_tx_byte;
                        txcmd_reg  <= i_tx_cmd;
                        txend_reg  <= i_tx_end;
                        o_tx_ready <= 1'b0;
                        src_reg    <= GMC_S_WAIT_RDY;
                    end
                end
                GMC_S_WAIT_RDY: begin
                    if (!nrfd) begin
                        settle_reg <= GMC_CNT_W'(GMC_SETTLE_CYC);
                        src_reg    <= GMC_S_SETTLE;
                    end
                end
                GMC_S_SETTLE: begin
                    if (settle_reg == '0) begin
                        src_reg <= GMC_S_WAIT_ACC;
                    end else begin
                        settle_reg <= settle_reg - 1'b1;
                    end
                end
                GMC_S_WAIT_ACC: begin
                    if (!ndac) begin
                        src_reg <= GMC_S_WAIT_NDAC;
                    end
                end
                GMC_S_WAIT_NDAC: begin
                    // data-valid dropped; wait for acceptors to rearm
                    if (ndac) begin
                        src_reg <= GMC_S_IDLE;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // acceptor handshake
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            acc_reg <= GMC_A_READY;
        end else begin
            unique case (acc_reg)
                GMC_A_READY: begin
                    if (dav && acceptor_on) begin
                        acc_reg <= GMC_A_ACCEPT;
                    end
                end
                GMC_A_ACCEPT: begin
                    acc_reg <= GMC_A_WAIT_END;
                end
                GMC_A_WAIT_END: begin
                    if (!dav) begin
                        acc_reg <= GMC_A_READY;
                    end
                end
            endcase
        end
    end

    assign strobe = (acc_reg == GMC_A_ACCEPT);

    gmc_decode u_decode (
        .i_mclk   (i_mclk),
        .i_reset  (i_reset),
        .i_strobe (strobe),
        .i_byte   (bus_data),
        .i_atn    (atn),
        .o_valid  (dec_valid),
        .o_msg    (dec_msg),
        .o_addr   (dec_addr)
    );

    // ************************************************************
    // received byte report
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rx_valid <= 1'b0;
            o_rx_byte  <= 8'h00;
            o_rx_cmd   <= 1'b0;
            o_rx_end   <= 1'b0;
            o_rx_msg   <= GMC_MSG_NONE;
            o_rx_addr  <= 5'h00;
            o_srq      <= 1'b0;
        end else begin
            o_rx_valid <= strobe;
            o_srq      <= srq;
            if (strobe) begin
                o_rx_byte <= bus_data;
                o_rx_cmd  <= atn;
                o_rx_end  <= eoi && !atn;
            end
            if (dec_valid) begin
                o_rx_msg  <= dec_msg;
                o_rx_addr <= dec_addr;
            end
        end
    end

    // ************************************************************
    // role tracking from the clear pulse and commands we send
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_cic    <= 1'b0;
            talk_reg <= 1'b0;
        end else begin
            if (ifc_reg && i_sys_ctrl) begin
                o_cic    <= 1'b1;
                talk_reg <= 1'b0;
            end else if (src_reg == GMC_S_WAIT_NDAC && ndac && txcmd_reg)
            begin
                if (txd_reg[6:0] == GMC_CMD_TCT[6:0]) begin
                    o_cic <= 1'b0;
                end
                if (txd_reg[6:0] == GMC_CMD_UNT[6:0]) begin
                    talk_reg <= 1'b0;
                end
            end
            if (i_tx_valid && o_tx_ready && i_tx_cmd && o_cic &&
                i_tx_byte[6:5] == 2'b10 &&
                i_tx_byte[4:0] <= GMC_ADDR_MAX) begin
                talk_reg <= 1'b1;       // any talk address 0 to 30 issued
            end
        end
    end

    // ************************************************************
    // interface clear pulse, system controller only
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ifc_reg     <= 1'b0;
            ifc_cnt_reg <= '0;
        end else if (i_ifc_req && i_sys_ctrl && !ifc_reg) begin
            ifc_reg     <= 1'b1;
            ifc_cnt_reg <= GMC_CNT_W'(GMC_SETTLE_CYC);
        end else if (ifc_reg) begin
            if (ifc_cnt_reg == '0) begin
                ifc_reg <= 1'b0;
            end else begin
                ifc_cnt_reg <= ifc_cnt_reg - 1'b1;
            end
        end
    end

    // ************************************************************
    // line drivers, registered, open drain, active low
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_dio_n   <= 8'hFF;
            o_dio_oe  <= 8'h00;
            o_dav_n   <= 1'b1;
            o_dav_oe  <= 1'b0;
            o_nrfd_n  <= 1'b1;
            o_nrfd_oe <= 1'b0;
            o_ndac_n  <= 1'b1;
            o_ndac_oe <= 1'b0;
            o_atn_n   <= 1'b1;
            o_atn_oe  <= 1'b0;
            o_ifc_n   <= 1'b1;
            o_ifc_oe  <= 1'b0;
            o_ren_n   <= 1'b1;
            o_ren_oe  <= 1'b0;
            o_eoi_n   <= 1'b1;
            o_eoi_oe  <= 1'b0;
        end else begin
            // data lines: low where a true bit is sent
            o_dio_n  <= (src_reg == GMC_S_IDLE) ? 8'hFF : ~txd_reg;
            o_dio_oe <= (src_reg == GMC_S_IDLE) ? 8'h00 : txd_reg;
            o_dav_n  <= ~(src_reg == GMC_S_WAIT_ACC);
            o_dav_oe <= (src_reg == GMC_S_WAIT_ACC);
            // not-ready held while busy; not-accepted until taken
            o_nrfd_n  <= ~(acceptor_on && acc_reg != GMC_A_READY);
            o_nrfd_oe <= acceptor_on && acc_reg != GMC_A_READY;
            o_ndac_n  <= ~(acceptor_on && acc_reg == GMC_A_READY);
            o_ndac_oe <= acceptor_on && acc_reg == GMC_A_READY;
            // attention during our commands or parallel poll
            o_atn_n  <= ~(o_cic && (txcmd_reg && src_reg != GMC_S_IDLE
                          || i_poll_req));
            o_atn_oe <= o_cic && (txcmd_reg && src_reg != GMC_S_IDLE
                          || i_poll_req);
            o_ifc_n  <= ~ifc_reg;
            o_ifc_oe <= ifc_reg;
            if (i_sys_ctrl && i_ren_set) begin
                o_ren_n  <= 1'b0;
                o_ren_oe <= 1'b1;
            end else if (i_ren_clr || !i_sys_ctrl) begin
                o_ren_n  <= 1'b1;
                o_ren_oe <= 1'b0;
            end
            // end with last data byte, or with attention for poll
            o_eoi_n  <= ~((txend_reg && !txcmd_reg &&
                          src_reg != GMC_S_IDLE) ||
                          (o_cic && i_poll_req));
            o_eoi_oe <= (txend_reg && !txcmd_reg &&
                          src_reg != GMC_S_IDLE) || (o_cic && i_poll_req);
        end
    end
endmodule

// [hw/gmc_decode.sv]
`timescale 1ns/10ps
// classifies one bus byte into a message class
module gmc_decode
    import gmc_pkg::*;
(
    // clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    // byte in
    input  wire logic       i_strobe,
    input  wire logic [7:0] i_byte,
    input  wire logic       i_atn,
    // result out, registered
    output logic            o_valid,
    output gmc_msg_t        o_msg,
    output logic [4:0]      o_addr
);
    logic [7:0] code;       // byte with parity bit ignored
    logic       ppc_reg;    // configure seen, followed only by enable/disable codes
    gmc_msg_t   msg_next;   // combinational class

    assign code = {1'b0, i_byte[6:0] & GMC_CODE_MASK};

    // ************************************************************
    // command classification
    // ************************************************************
    always_comb begin
        msg_next = GMC_MSG_NONE;
        if (!i_atn) begin
            msg_next = GMC_MSG_DATA;
        end else if (code == GMC_CMD_GTL) begin
            msg_next = GMC_MSG_GTL;
        end else if (code == GMC_CMD_SDC) begin
            msg_next = GMC_MSG_SDC;
        end else if (code == GMC_CMD_PPC) begin
            msg_next = GMC_MSG_PPC;
        end else if (code == GMC_CMD_GET) begin
            msg_next = GMC_MSG_GET;
        end else if (code == GMC_CMD_TCT) begin
            msg_next = GMC_MSG_TCT;
        end else if (code == GMC_CMD_LLO) begin
            msg_next = GMC_MSG_LLO;
        end else if (code == GMC_CMD_DCL) begin
            msg_next = GMC_MSG_DCL;
        end else if (code == GMC_CMD_PPU) begin
            msg_next = GMC_MSG_PPU;
        end else if (code == GMC_CMD_SPE) begin
            msg_next = GMC_MSG_SPE;
        end else if (code == GMC_CMD_SPD) begin
            msg_next = GMC_MSG_SPD;
        end else if (code == GMC_CMD_UNL) begin
            msg_next = GMC_MSG_UNL;
        end else if (code >= GMC_LISTEN_BASE && code < GMC_CMD_UNL) begin
            msg_next = GMC_MSG_LISTEN;
        end else if (code == GMC_CMD_UNT) begin
            msg_next = GMC_MSG_UNT;
        end else if (code >= GMC_TALK_BASE && code < GMC_CMD_UNT) begin
            msg_next = GMC_MSG_TALK;
        end else if (code >= GMC_SEC_BASE && code <= GMC_SEC_LAST) begin
            if (!ppc_reg) begin
                msg_next = GMC_MSG_SEC;
            end else if (code <= GMC_PPE_LAST) begin
                msg_next = GMC_MSG_PPE;
            end else begin
                msg_next = GMC_MSG_PPD;
            end
        end
    end

    // ************************************************************
    // configure memory: next secondary acts as enable/disable
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            ppc_reg <= 1'b0;
        end else if (i_strobe && i_atn) begin
            ppc_reg <= (msg_next == GMC_MSG_PPC) ||
                       (ppc_reg && (msg_next == GMC_MSG_PPE ||
                                    msg_next == GMC_MSG_PPD));
        end
    end

    // ************************************************************
    // registered result
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            o_msg   <= GMC_MSG_NONE;
            o_addr  <= 5'h00;
        end else begin
            o_valid <= i_strobe;
            if (i_strobe) begin
                o_msg  <= msg_next;
                o_addr <= code[4:0];
            end
        end
    end
endmodule

// [hw/gmc_pkg.sv]
package gmc_pkg;
    // ************************************************************
    // command byte codes
    // ************************************************************
    localparam logic [7:0] GMC_CMD_GTL   = 8'h01;  // go to local
    localparam logic [7:0] GMC_CMD_SDC   = 8'h04;  // selected device clear
    localparam logic [7:0] GMC_CMD_PPC   = 8'h05;  // parallel poll configure
    localparam logic [7:0] GMC_CMD_GET   = 8'h08;  // group execute trigger
    localparam logic [7:0] GMC_CMD_TCT   = 8'h09;  // take control
    localparam logic [7:0] GMC_CMD_LLO   = 8'h11;  // local lockout
    localparam logic [7:0] GMC_CMD_DCL   = 8'h14;  // device clear
    localparam logic [7:0] GMC_CMD_PPU   = 8'h15;  // parallel poll unconfigure
    localparam logic [7:0] GMC_CMD_SPE   = 8'h18;  // serial poll enable
    localparam logic [7:0] GMC_CMD_SPD   = 8'h19;  // serial poll disable
    localparam logic [7:0] GMC_LISTEN_BASE = 8'h20; // listen address base
    localparam logic [7:0] GMC_CMD_UNL   = 8'h3F;  // unlisten
    localparam logic [7:0] GMC_TALK_BASE = 8'h40;  // talk address base
    localparam logic [7:0] GMC_CMD_UNT   = 8'h5F;  // untalk
    localparam logic [7:0] GMC_SEC_BASE  = 8'h60;  // secondary base
    localparam logic [7:0] GMC_PPE_LAST  = 8'h6F;  // last enable code
    localparam logic [7:0] GMC_PPD_FIRST = 8'h70;  // first disable code
    localparam logic [7:0] GMC_SEC_LAST  = 8'h7E;  // last secondary
    localparam logic [6:0] GMC_CODE_MASK = 7'h7F;  // 7-bit code mask
    localparam int         GMC_PAR_BIT   = 7;      // parity / unused bit
    localparam logic [4:0] GMC_ADDR_MAX  = 5'h1E;  // highest address 30

    // ************************************************************
    // timing: data settle time before data-valid
    // ************************************************************
    localparam int GMC_CLK_NS    = 8;     // clock period
    localparam int GMC_SETTLE_NS = 500;   // least settle time
    localparam int GMC_SETTLE_CYC =
        (GMC_SETTLE_NS + GMC_CLK_NS - 1) / GMC_CLK_NS;
    localparam int GMC_CNT_W     = 7;     // settle counter width

    // ************************************************************
    // decoded message classes
    // ************************************************************
    typedef enum logic [4:0] {
        GMC_MSG_NONE, GMC_MSG_GTL, GMC_MSG_SDC, GMC_MSG_PPC,
        GMC_MSG_GET, GMC_MSG_TCT, GMC_MSG_LLO, GMC_MSG_DCL,
        GMC_MSG_PPU, GMC_MSG_SPE, GMC_MSG_SPD, GMC_MSG_LISTEN,
        GMC_MSG_UNL, GMC_MSG_TALK, GMC_MSG_UNT, GMC_MSG_SEC,
        GMC_MSG_PPE, GMC_MSG_PPD, GMC_MSG_DATA
    } gmc_msg_t;
endpackage

// [hw/gmc_sync.sv]
`timescale 1ns/10ps
// two-flop synchroniser, one per bit
module gmc_sync
    import gmc_pkg::*;
#(
    parameter int W = 1
) (
    // clock
    input  wire logic         i_mclk,
    // asynchronous levels in, synchronised out
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;  // first stage, read only by second

    // ************************************************************
    // two flip-flop stages
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        meta_reg <= i_async;
        o_sync   <= meta_reg;
    end
endmodule

// [sim/gmc_bus_model.sv]
`timescale 1ns/10ps
// far instrument: acceptor whenever it is not sourcing, source when asked
module gmc_bus_model
    import gmc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] dio_n,
    input  wire logic       dav_n, nrfd_n, ndac_n, atn_n, eoi_n,
    output logic      [7:0] dio,
    output logic            dav, nrfd, ndac, eoi
);
    logic       src = 0;      // we source the byte
    logic       nr = 0;       // acceptor holds off
    logic       nd = 1;       // acceptor not yet taken
    logic [9:0] rxq[$];       // taken {atn, eoi, byte}
    assign nrfd = nr & !src;
    assign ndac = nd & !src;
    initial begin
        dio = 0;
        dav = 0;
        eoi = 0;
    end
    // acceptor: take each byte once, random delay
    initial forever begin
        @(posedge clk iff dav_n === 1'b0 && !src);
        #1 nr = 1;
        repeat ($urandom % 5) @(posedge clk);
        rxq.push_back({~atn_n, ~eoi_n, ~dio_n});
        #1 nd = 0;
        @(posedge clk iff dav_n === 1'b1);
        #1 nd = 1;
        nr = 0;
    end
    // source one data byte; released lines float high
    task automatic send(input logic [7:0] b, input logic e);
        src = 1;
        @(posedge clk iff nrfd_n === 1'b1);
        #1 dio = b;
        eoi = e;
        repeat (GMC_SETTLE_CYC) @(posedge clk);
        #1 dav = 1;
        @(posedge clk iff ndac_n === 1'b1);
        #1 dav = 0;
        dio = 0;
        eoi = 0;
        @(posedge clk iff ndac_n === 1'b0);
        #1 src = 0;
    endtask
endmodule

// [sim/gmc_ctrl_sva.sv]
`timescale 1ns/10ps
// ****************************************
// handshake order and line ownership
// ****************************************
module gmc_ctrl_sva (
    input wire logic       i_mclk, i_reset, i_sys_ctrl,
    input wire logic       i_nrfd_n, i_ndac_n, i_srq_n,
    input wire logic [7:0] o_dio_n,
    input wire logic       o_dav_oe, o_atn_oe, o_atn_n, o_cic,
    input wire logic       o_ifc_oe, o_ren_oe, o_srq, o_rx_valid
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    property p_dav_rdy; $rose(o_dav_oe) |-> i_nrfd_n; endproperty
    a_dav_rdy: assert property (p_dav_rdy) else $error("dav early");
    property p_dav_end; $fell(o_dav_oe) |-> $past(i_ndac_n); endproperty
    a_dav_end: assert property (p_dav_end) else $error("dav drop");
    property p_dio; o_dav_oe && $past(o_dav_oe) |-> $stable(o_dio_n);
    endproperty
    a_dio: assert property (p_dio) else $error("data moved");
    property p_cmd; $rose(o_dav_oe) && o_atn_oe |-> o_cic; endproperty
    a_cmd: assert property (p_cmd) else $error("cmd not cic");
    property p_ifc; o_ifc_oe |-> i_sys_ctrl; endproperty
    a_ifc: assert property (p_ifc) else $error("clear owner");
    property p_ren; o_ren_oe |-> i_sys_ctrl; endproperty
    a_ren: assert property (p_ren) else $error("remote owner");
    property p_srq; !i_srq_n [*5] |-> o_srq; endproperty
    a_srq: assert property (p_srq) else $error("srq missed");
    property p_once; o_rx_valid |=> !o_rx_valid; endproperty
    a_once: assert property (p_once) else $error("byte twice");
    property p_low; o_atn_oe |-> !o_atn_n; endproperty
    a_low: assert property (p_low) else $error("atn level");
endmodule
bind gmc_ctrl gmc_ctrl_sva u_sva (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_sys_ctrl(i_sys_ctrl), .i_nrfd_n(i_nrfd_n), .i_ndac_n(i_ndac_n),
    .i_srq_n(i_srq_n), .o_dio_n(o_dio_n), .o_dav_oe(o_dav_oe),
    .o_atn_oe(o_atn_oe), .o_atn_n(o_atn_n), .o_cic(o_cic),
    .o_ifc_oe(o_ifc_oe), .o_ren_oe(o_ren_oe), .o_srq(o_srq),
    .o_rx_valid(o_rx_valid));

// [sim/tb.sv]
`timescale 1ns/10ps
// ****************************************
// controller bench with far-side model
// ****************************************
module tb;
    import gmc_pkg::*;
    logic i_mclk = 0, i_reset = 1, i_sys_ctrl = 1, i_talk_only = 0;
    logic i_listen_only = 0, i_tx_valid = 0, i_tx_cmd = 0, i_tx_end = 0;
    logic i_ifc_req = 0, i_ren_set = 0, i_ren_clr = 0, i_poll_req = 0;
    logic i_listen_en = 0, m_srq = 0, rv_d = 0;
    logic [7:0] i_tx_byte = 0, i_dio_n, o_dio_n, o_dio_oe, o_rx_byte, m_dio;
    logic o_tx_ready, o_rx_valid, o_rx_cmd, o_rx_end, o_cic, o_srq;
    logic i_dav_n, o_dav_n, o_dav_oe, i_nrfd_n, o_nrfd_n, o_nrfd_oe;
    logic i_ndac_n, o_ndac_n, o_ndac_oe, i_atn_n, o_atn_n, o_atn_oe;
    logic o_ifc_n, o_ifc_oe, o_ren_n, o_ren_oe, i_srq_n, i_eoi_n;
    logic o_eoi_n, o_eoi_oe, m_dav, m_nrfd, m_ndac, m_eoi;
    logic [4:0] o_rx_addr;
    gmc_msg_t o_rx_msg;
    int fails = 0, checked = 0, cyc = 0, a;
    logic [9:0] exq[$], erq[$], rq[$];
    logic [7:0] cl[14] = '{8'h65, 8'h3F, 8'h5F, 8'h01, 8'h04, 8'h05, 8'h60,
        8'h70, 8'h08, 8'h11, 8'h14, 8'h15, 8'h18, 8'h19};
    gmc_msg_t ex[14] = '{GMC_MSG_SEC, GMC_MSG_UNL, GMC_MSG_UNT, GMC_MSG_GTL,
        GMC_MSG_SDC, GMC_MSG_PPC, GMC_MSG_PPE, GMC_MSG_PPD, GMC_MSG_GET,
        GMC_MSG_LLO, GMC_MSG_DCL, GMC_MSG_PPU, GMC_MSG_SPE, GMC_MSG_SPD};
    always #4 i_mclk = ~i_mclk;
    // wired bus: low if anyone pulls, pull-up otherwise
    assign i_dio_n = ~(o_dio_oe & ~o_dio_n | m_dio);
    assign i_dav_n = ~(o_dav_oe & ~o_dav_n | m_dav);
    assign i_nrfd_n = ~(o_nrfd_oe & ~o_nrfd_n | m_nrfd);
    assign i_ndac_n = ~(o_ndac_oe & ~o_ndac_n | m_ndac);
    assign i_atn_n = ~(o_atn_oe & ~o_atn_n);
    assign i_eoi_n = ~(o_eoi_oe & ~o_eoi_n | m_eoi);
    assign i_srq_n = ~m_srq;
    gmc_ctrl u_dut (.*);
    gmc_bus_model u_bus (.clk(i_mclk), .dio_n(i_dio_n), .dav_n(i_dav_n),
        .nrfd_n(i_nrfd_n), .ndac_n(i_ndac_n), .atn_n(i_atn_n),
        .eoi_n(i_eoi_n), .dio(m_dio), .dav(m_dav), .nrfd(m_nrfd),
        .ndac(m_ndac), .eoi(m_eoi));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one byte out through the user port, waits for completion
    task automatic tx(input logic [7:0] b, input logic c, input logic e,
        input gmc_msg_t m = GMC_MSG_NONE);
        @(posedge i_mclk);
        #1 i_tx_valid = 1;
        i_tx_byte = b;
        i_tx_cmd = c;
        i_tx_end = e;
        @(posedge i_mclk iff o_tx_ready === 1'b1);
        #1 i_tx_valid = 0;
        exq.push_back({c, e & !c, b});
        @(posedge i_mclk iff o_tx_ready === 1'b1);
        if (c) chk({o_rx_cmd, o_rx_msg, o_rx_addr},
            {1'b1, m, b[4:0]});
    endtask
    // received bytes while the model sources, message class a cycle on
    always @(posedge i_mclk) begin
        rv_d <= o_rx_valid && u_bus.src;
        if (o_rx_valid && u_bus.src) rq.push_back({o_rx_cmd, o_rx_end, o_rx_byte});
        if (rv_d) chk(o_rx_msg, GMC_MSG_DATA);
        cyc++;
        if (cyc == 12000) begin
            fails++;
            final_report;
        end
    end
    initial begin
        void'($urandom(32'hCCB3));
        repeat (12) @(posedge i_mclk);
        #1 i_reset = 0;
        @(posedge i_mclk);
        #1 i_ifc_req = 1;
        i_ren_set = 1;
        m_srq = 1;
        @(posedge i_mclk);
        #1 i_ifc_req = 0;
        i_ren_set = 0;
        @(posedge i_mclk iff o_cic === 1'b1);
        #1 chk({o_ren_oe, o_ren_n, o_ifc_oe, o_ifc_n}, 4'hA);
        chk(o_srq, 1);
        m_srq = 0;
        $display("test mgmt done");
        a = $urandom % 31;
        foreach (cl[i]) tx(cl[i], 1, 0, ex[i]);
        tx(8'h20 + a[7:0], 1, 0, GMC_MSG_LISTEN);
        tx(8'h40 + a[7:0], 1, 0, GMC_MSG_TALK);
        $display("test cmds done");
        for (int i = 0; i < 4; i++) tx(8'($urandom), 0, i == 3);
        $display("test data out done");
        #1;
        for (int i = 0; i < 3; i++) begin
            {i_listen_en, i_listen_only} = (i == 1) ? 2'b01 : 2'b10;
            a = $urandom;
            erq.push_back({1'b0, i == 2, a[7:0]});
            u_bus.send(a[7:0], i == 2);
        end
        {i_listen_en, i_listen_only} = 2'b00;
        i_poll_req = 1;
        i_ren_clr = 1;
        chk(rq.size(), 3);
        foreach (erq[i]) chk(rq[i], erq[i]);
        $display("test data in done");
        repeat (2) @(posedge i_mclk);
        #1 chk({o_atn_oe, o_atn_n, o_eoi_oe, o_eoi_n}, 4'hA);
        chk(o_ren_oe, 0);
        i_poll_req = 0;
        i_ren_clr = 0;
        $display("test poll done");
        tx(8'h09, 1, 0, GMC_MSG_TCT);
        chk(o_cic, 0);
        chk(u_bus.rxq.size(), exq.size());
        foreach (exq[i]) chk(u_bus.rxq[i], exq[i]);
        $display("test handover done");
        final_report;
    end
endmodule
